// file: logic/ffm_fast_load.sv
// Fast frequency-multiplier load path with lock-value record and Avalon-MM registers
// Functional notes
// - Fast command only when core on, host off
// - Lock value split: low byte, upper six
// - Plain load makes multiplier search lock value
// - Fast loads N, M, lock; prescaler zero
// - Fast leaves prescale setting register unchanged
// - Fast load locks without any search
// - Stale lock value converges toward target
// - Oscillator held low while searching or settling
// - Valid at bit 4, fast bit 1, reset 0C
//
// The register offsets and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/10ps
module ffm_fast_load (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Avalon-MM slave
	input wire ffm_pkg::ffm_avm_req_t avm_req,
	output logic waitrequest,
	output logic [ffm_pkg::DATA_W-1:0] readdata,
	// Clock-domain enables from power management and host side
	input wire logic core_enable,
	input wire logic host_enable,
	// Frequency multiplier and prescaler
	output ffm_pkg::ffm_mult_cfg_t mult_cfg,
	output logic [ffm_pkg::PRESCALE_W-1:0] prescale_div,
	output logic osc_enable
);
	import ffm_pkg::*;

	logic [7:0] ctrl_stored;
	logic [7:0] m_low;
	logic [7:0] m_high;
	logic [7:0] n_val;
	logic [LOCK_LO_W-1:0] lock_sup_low;
	logic [LOCK_HI_W-1:0] lock_sup_high;
	logic [PRESCALE_W-1:0] prescale_set;
	logic [LOCK_HI_W-1:0] snap_high;
	logic lock_valid;
	logic [LOCK_W-1:0] live;
	logic [CNT_W-1:0] settle_cnt;
	ffm_state_t state;
	ffm_state_t next_state;

	// Bus decode
	wire req = avm_req.read | avm_req.write;
	wire accept = req & ~waitrequest;
	wire wr_acc = accept & avm_req.write;
	wire rd_start = avm_req.read & waitrequest;
	wire hit_ctrl = avm_req.address == OFF_CTRL;
	wire hit_m_low = avm_req.address == OFF_M_LOW;
	wire hit_m_high = avm_req.address == OFF_M_HIGH;
	wire hit_n = avm_req.address == OFF_N;
	wire hit_lock_low = avm_req.address == OFF_LOCK_LOW;
	wire hit_lock_high = avm_req.address == OFF_LOCK_HIGH;
	wire hit_prescale = avm_req.address == OFF_PRESCALE;
	wire [7:0] wbyte = avm_req.writedata[7:0];

	wire cmd_ok = core_enable & ~host_enable;
	wire ctrl_wr = wr_acc & hit_ctrl;
	// fast command takes priority over plain load
	wire fast_go = ctrl_wr & wbyte[CTRL_FAST] & cmd_ok;
	wire load_go = ctrl_wr & wbyte[CTRL_LOAD] & ~wbyte[CTRL_FAST] & cmd_ok;
	wire [LOCK_W-1:0] lock_sup = {lock_sup_high, lock_sup_low};

	// Model of the loop: the lock value that hits the target for the loaded M and N
	wire [LOCK_W-1:0] target_lock = {mult_cfg.m_high[LOCK_HI_W-1:0], mult_cfg.m_low ^ mult_cfg.n};
	wire at_target = live == target_lock;
	wire [LOCK_W-1:0] live_step = (live < target_lock) ? live + LOCK_STEP : live - LOCK_STEP;
	// only a settled loop gives a coherent pair
	wire live_stable = state == ST_LOCKED;
	wire [7:0] ctrl_rd = (ctrl_stored & CTRL_STORED) | ({7'h00, lock_valid} << CTRL_VALID);

	// lock value halves on the bus, upper bits from the capture
	wire [7:0] rd_mux =
		hit_ctrl ? ctrl_rd :
		hit_m_low ? m_low :
		hit_m_high ? m_high :
		hit_n ? n_val :
		hit_lock_low ? live[LOCK_LO_W-1:0] :
		hit_lock_high ? {2'b00, snap_high} :
		hit_prescale ? {3'b000, prescale_set} : BYTE_RESET;

	always_comb begin
		next_state = state;
		unique case (state)
			ST_LOCKED: next_state = ST_LOCKED;
			ST_SEARCH: if (at_target) next_state = ST_LOCKED;
			ST_SETTLE: if (settle_cnt == CNT_ONE) next_state = ST_CONVERGE;
			ST_CONVERGE: if (at_target) next_state = ST_LOCKED;
		endcase
		if (load_go)
			next_state = ST_SEARCH;
		if (fast_go)
			next_state = ST_SETTLE;
	end

	// One wait cycle per access; read data prepared during it
	always_ff @(posedge clk) begin
		if (reset) begin
			waitrequest <= 1'b1;
			readdata <= '0;
		end else begin
			waitrequest <= ~(req & waitrequest);
			if (rd_start)
				readdata <= {24'h0000_00, rd_mux};
		end
	end

	// Software registers; command bits self-clear and read as zero
	always_ff @(posedge clk) begin
		if (reset) begin
			ctrl_stored <= CTRL_RESET;
			m_low <= BYTE_RESET;
			m_high <= BYTE_RESET;
			n_val <= BYTE_RESET;
			lock_sup_low <= BYTE_RESET;
			lock_sup_high <= LOCK_HI_W'(BYTE_RESET);
			prescale_set <= PRESCALE_RESET;
		end else if (wr_acc) begin
			if (hit_ctrl)
				ctrl_stored <= wbyte & CTRL_STORED;
			if (hit_m_low)
				m_low <= wbyte;
			if (hit_m_high)
				m_high <= wbyte;
			if (hit_n)
				n_val <= wbyte;
			if (hit_lock_low)
				lock_sup_low <= wbyte;
			if (hit_lock_high)
				lock_sup_high <= wbyte[LOCK_HI_W-1:0];
			// only software writes the prescale setting
			if (hit_prescale)
				prescale_set <= wbyte[PRESCALE_W-1:0];
		end
	end

	// capture upper bits and validity on the low-byte read
	always_ff @(posedge clk) begin
		if (reset) begin
			snap_high <= LOCK_HI_W'(BYTE_RESET);
			lock_valid <= 1'b0;
		end else if (rd_start && hit_lock_low) begin
			snap_high <= live[LOCK_W-1:LOCK_LO_W];
			lock_valid <= live_stable;
		end
	end

	// one-step transfer into the multiplier, prescaler to divide by one
	always_ff @(posedge clk) begin
		if (reset) begin
			mult_cfg <= '0;
			prescale_div <= PRESCALE_DIV1;
		end else if (fast_go || load_go) begin
			mult_cfg.m_high <= m_high;
			mult_cfg.m_low <= m_low;
			mult_cfg.n <= n_val;
			mult_cfg.lock <= fast_go ? lock_sup : live;
			prescale_div <= PRESCALE_DIV1;
		end
	end

	// Loop state; search and convergence both walk one step per clock
	always_ff @(posedge clk) begin
		if (reset) begin
			state <= ST_LOCKED;
			live <= LOCK_RESET;
			settle_cnt <= CNT_ZERO;
			osc_enable <= 1'b0;
		end else begin
			state <= next_state;
			if (fast_go)
				live <= lock_sup;
			// keep adjusting after a stale lock value
			else if (!load_go && (state == ST_SEARCH || state == ST_CONVERGE) && !at_target)
				live <= live_step;
			settle_cnt <= fast_go ? CNT_W'(SETTLE_CYCLES) : (settle_cnt == CNT_ZERO ? CNT_ZERO : settle_cnt - CNT_ONE);
			// output gated while searching or settling
			osc_enable <= next_state == ST_LOCKED || next_state == ST_CONVERGE;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence s_fast_cmd;
		fast_go;
	endsequence

	sequence s_settle_run;
		(state == ST_SETTLE && !osc_enable) [*8];
	endsequence

	AST_FAST_GATED: assert property (ctrl_wr && wbyte[CTRL_FAST] && !cmd_ok |=> $stable(mult_cfg))
		else $error("fast command taken outside core-only state");
	AST_FAST_TRANSFER: assert property (s_fast_cmd |=> mult_cfg.lock == $past(lock_sup)
		&& mult_cfg.n == $past(n_val) && mult_cfg.m_low == $past(m_low) && prescale_div == PRESCALE_DIV1)
		else $error("fast command did not transfer values");
	AST_PRESCALE_KEPT: assert property (s_fast_cmd |=> $stable(prescale_set))
		else $error("prescale setting changed by fast command");
	AST_FAST_NO_SEARCH: assert property (s_fast_cmd |=> s_settle_run)
		else $error("fast command did not settle without search");
	AST_LOAD_SEARCH: assert property (load_go |=> state == ST_SEARCH && !osc_enable)
		else $error("plain load did not start a search");
	AST_OSC_LOW: assert property (!$past(reset) |-> osc_enable == (state == ST_LOCKED || state == ST_CONVERGE))
		else $error("oscillator output not held low while acquiring");
	AST_CONVERGE_STEP: assert property (state == ST_CONVERGE && live < target_lock && !load_go && !fast_go
		|=> live == $past(live) + LOCK_STEP)
		else $error("lock value not converging");
	AST_VALID_BIT: assert property (rd_start && hit_ctrl |=> readdata[CTRL_VALID] == lock_valid
		&& readdata[CTRL_FAST] == 1'b0)
		else $error("control readback wrong");
	AST_COHERENT: assert property (rd_start && hit_lock_low |=> lock_valid == $past(live_stable)
		&& snap_high == $past(live[LOCK_W-1:LOCK_LO_W]) && readdata[7:0] == $past(live[7:0]))
		else $error("lock value capture incoherent");
	AST_HIGH_READ: assert property (rd_start && hit_lock_high |=> readdata == {26'h000_0000, snap_high})
		else $error("upper lock bits read wrong");
endmodule

// file: logic/ffm_pkg.sv
// Constants, carriers and states of the fast frequency-multiplier load block
package ffm_pkg;
	// Register byte offsets on the Avalon-MM slave
	localparam int ADDR_W = 5;
	localparam logic [ADDR_W-1:0] OFF_CTRL = 5'h00;
	localparam logic [ADDR_W-1:0] OFF_M_LOW = 5'h04;
	localparam logic [ADDR_W-1:0] OFF_M_HIGH = 5'h08;
	localparam logic [ADDR_W-1:0] OFF_N = 5'h0C;
	localparam logic [ADDR_W-1:0] OFF_LOCK_LOW = 5'h10;
	localparam logic [ADDR_W-1:0] OFF_LOCK_HIGH = 5'h14;
	localparam logic [ADDR_W-1:0] OFF_PRESCALE = 5'h18;
	// Control register layout
	localparam int CTRL_LOAD = 0;
	localparam int CTRL_FAST = 1;
	localparam int CTRL_VALID = 4;
	localparam logic [7:0] CTRL_RESET = 8'h0C;
	localparam logic [7:0] CTRL_STORED = 8'h0C;
	// Field widths and reset values
	localparam int DATA_W = 32;
	localparam int LOCK_W = 14;
	localparam int LOCK_LO_W = 8;
	localparam int LOCK_HI_W = 6;
	localparam int PRESCALE_W = 5;
	localparam logic [PRESCALE_W-1:0] PRESCALE_DIV1 = 5'h00;
	localparam logic [PRESCALE_W-1:0] PRESCALE_RESET = 5'h00;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [LOCK_W-1:0] LOCK_RESET = 14'h0000;
	localparam logic [LOCK_W-1:0] LOCK_STEP = 14'h0001;
	// Timing: settle time after a fast load before the output runs
	localparam int CLK_MHZ = 40;
	localparam int SETTLE_NS = 1000;
	localparam int SETTLE_CYCLES = (SETTLE_NS * CLK_MHZ + 999) / 1000;
	localparam int CNT_W = 6;
	localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
	localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;

	typedef struct packed {
		logic read;
		logic write;
		logic [ADDR_W-1:0] address;
		logic [DATA_W-1:0] writedata;
	} ffm_avm_req_t;

	typedef struct packed {
		logic [7:0] m_high;
		logic [7:0] m_low;
		logic [7:0] n;
		logic [LOCK_W-1:0] lock;
	} ffm_mult_cfg_t;

	typedef enum logic [3:0] {
		ST_LOCKED = 4'b0001,
		ST_SEARCH = 4'b0010,
		ST_SETTLE = 4'b0100,
		ST_CONVERGE = 4'b1000
	} ffm_state_t;
endpackage

// file: testbench/tb_ffm_fast_load.sv
// Self-checking bench for the fast frequency-multiplier load block
`timescale 1ns/10ps
module tb_ffm_fast_load;
	import ffm_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	ffm_avm_req_t avm_req = '0;
	logic core_enable = 1'b1;
	logic host_enable = 1'b0;
	logic waitrequest;
	logic [DATA_W-1:0] readdata;
	ffm_mult_cfg_t mult_cfg;
	logic [PRESCALE_W-1:0] prescale_div;
	logic osc_enable;
	int miscompares = 0;
	int comparisons = 0;
	int cycles = 0;
	int seed = 53;
	int i;
	int k;
	logic [7:0] q, lo, n, ml, mh;
	logic [4:0] pre;
	logic [LOCK_W-1:0] lk, v;
	ffm_mult_cfg_t held;

	always #12.5 clk = ~clk;

	ffm_fast_load dut (.clk(clk), .reset(reset), .avm_req(avm_req), .waitrequest(waitrequest),
		.readdata(readdata), .core_enable(core_enable), .host_enable(host_enable),
		.mult_cfg(mult_cfg), .prescale_div(prescale_div), .osc_enable(osc_enable));

	task automatic report_and_stop();
		if (miscompares == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Request held until waitrequest is sampled low, then released
	task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
		int w;
		w = 0;
		@(posedge clk);
		avm_req.read <= ~wr;
		avm_req.write <= wr;
		avm_req.address <= a;
		avm_req.writedata <= {24'h00_0000, d};
		do begin
			@(posedge clk);
			w++;
		end while (waitrequest !== 1'b0);
		q = readdata[7:0];
		chk(w, 2); // one wait state per access
		if (!wr) chk(readdata[31:8], 24'h00_0000); // upper bytes read zero
		avm_req.read <= 1'b0;
		avm_req.write <= 1'b0;
	endtask

	task automatic wait_osc(input int lim);
		k = 0;
		while (osc_enable !== 1'b1 && k < lim) begin
			@(posedge clk);
			#1;
			k++;
		end
		chk(osc_enable, 1'b1); // output runs again
	endtask

	// low byte, valid poll, upper bits
	task automatic rec(output logic [LOCK_W-1:0] val);
		int t = 0;
		do begin
			bus(1'b0, OFF_LOCK_LOW, 8'h00);
			lo = q;
			bus(1'b0, OFF_CTRL, 8'h00);
			t++;
		end while (q[CTRL_VALID] !== 1'b1 && t < 6000);
		chk(q[CTRL_VALID], 1'b1); // valid seen before high read
		bus(1'b0, OFF_LOCK_HIGH, 8'h00);
		val = {q[5:0], lo};
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 90000) begin
			miscompares++;
			report_and_stop();
		end
	end

	initial begin
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		bus(1'b0, OFF_CTRL, 8'h00);
		chk(q, CTRL_RESET); // reset value
		bus(1'b1, 5'h1C, 8'hA5);
		bus(1'b0, 5'h1C, 8'h00);
		chk(q, 8'h00); // unmapped reads zero
		pre = 5'($random(seed));
		bus(1'b1, OFF_PRESCALE, {3'h0, pre});
		for (i = 0; i < 3; i++) begin
			n = 8'($random(seed));
			ml = 8'($random(seed));
			mh = 8'($random(seed));
			lk = 14'($random(seed));
			// Near-correct supplied value first, then a stale one
			if (i == 0) lk = {mh[5:0], ml ^ n} ^ {10'h000, lk[3:0]};
			@(posedge clk);
			host_enable <= (i == 2);
			bus(1'b1, OFF_N, n);
			bus(1'b1, OFF_M_LOW, ml);
			bus(1'b1, OFF_M_HIGH, mh);
			bus(1'b1, OFF_LOCK_LOW, lk[7:0]);
			bus(1'b1, OFF_LOCK_HIGH, {2'h0, lk[13:8]});
			held = mult_cfg;
			// Second pass sets load and fast together: fast must win
			bus(1'b1, OFF_CTRL, (i == 1) ? 8'h0F : 8'h0E);
			#1;
			if (i == 2) begin
				chk(mult_cfg, held); // refused with host side on
				@(posedge clk);
				host_enable <= 1'b0;
				core_enable <= 1'b0;
				bus(1'b1, OFF_CTRL, 8'h0E);
				#1;
				chk(mult_cfg, held); // refused with core off
				@(posedge clk);
				core_enable <= 1'b1;
			end else begin
				chk(mult_cfg, {mh, ml, n, lk}); // one-step load
				chk(prescale_div, PRESCALE_DIV1); // divide by one
				chk(osc_enable, 1'b0); // held low
				wait_osc(100);
				chk(k >= SETTLE_CYCLES - 1 && k <= SETTLE_CYCLES + 2, 1'b1); // no search
				bus(1'b0, OFF_PRESCALE, 8'h00);
				chk(q, {3'h0, pre}); // setting untouched
				bus(1'b0, OFF_CTRL, 8'h00);
				chk(q[3:0], 4'hC); // fast bit reads zero
				rec(v);
				chk(v, {mh[5:0], ml ^ n}); // converged
			end
		end
		bus(1'b1, OFF_N, n ^ 8'h01);
		bus(1'b1, OFF_CTRL, 8'h0D);
		#1;
		chk({mult_cfg.m_high, mult_cfg.m_low, mult_cfg.n}, {mh, ml, n ^ 8'h01}); // plain load
		chk(osc_enable, 1'b0); // held low while searching
		wait_osc(20000);
		rec(v);
		chk(v, {mh[5:0], ml ^ n ^ 8'h01}); // search reaches target
		report_and_stop();
	end
endmodule
